// >>> src/reset_init_values_consts.vh
`ifndef RESET_INIT_VALUES_CONSTS_VH
`define RESET_INIT_VALUES_CONSTS_VH

// entry layout: {keep on non-power-on reset, address, power-on value, implemented mask}
`define ENT_KEEP 25
`define ENT_ADDR_HI 24
`define ENT_ADDR_LO 16
`define ENT_POR_HI 15
`define ENT_POR_LO 8
`define ENT_MASK_HI 7
`define ENT_MASK_LO 0

`define E_CAPTURE2_VALUE_HIGH {1'b1, 9'h01c, 8'h00, 8'hff}
`define E_CAPTURE2_CONTROL {1'b0, 9'h01d, 8'h00, 8'h3f}
`define E_CONVERTER_RESULT_HIGH {1'b1, 9'h01e, 8'h00, 8'hff}
`define E_CONVERTER_CONTROL_0 {1'b0, 9'h01f, 8'h00, 8'hdf}
`define E_CORE_OPTION_SETTINGS {1'b0, 9'h081, 8'hff, 8'hff}
`define E_PORT_A_DIRECTION {1'b0, 9'h085, 8'hff, 8'hff}
`define E_PORT_B_DIRECTION {1'b0, 9'h086, 8'hff, 8'hff}
`define E_PORT_C_DIRECTION {1'b0, 9'h087, 8'hff, 8'hff}
`define E_PORT_D_DIRECTION {1'b0, 9'h088, 8'hff, 8'hff}
`define E_PORT_E_DIRECTION {1'b0, 9'h089, 8'h0f, 8'h0f}
`define E_PERIPHERAL_IRQ_ENABLE_1 {1'b0, 9'h08c, 8'h00, 8'hff}
`define E_PERIPHERAL_IRQ_ENABLE_2 {1'b0, 9'h08d, 8'h00, 8'hff}
`define E_POWER_CONTROL_STATUS {1'b1, 9'h08e, 8'h10, 8'h33}
`define E_OSCILLATOR_CONTROL {1'b0, 9'h08f, 8'h60, 8'h7f}
`define E_OSCILLATOR_TUNING {1'b1, 9'h090, 8'h00, 8'h1f}
`define E_SERIAL_PORT_CONTROL_2 {1'b0, 9'h091, 8'h00, 8'hff}
`define E_TIMER2_PERIOD {1'b0, 9'h092, 8'hff, 8'hff}
`define E_SERIAL_SLAVE_ADDRESS {1'b0, 9'h093, 8'h00, 8'hff}
`define E_SERIAL_ADDRESS_MASK {1'b0, 9'h093, 8'hff, 8'hff}
`define E_SERIAL_PORT_STATE {1'b0, 9'h094, 8'h00, 8'hff}
`define E_PORT_B_PULLUP_ENABLE {1'b0, 9'h095, 8'hff, 8'hff}
`define E_PORT_B_CHANGE_IRQ_ENABLE {1'b0, 9'h096, 8'h00, 8'hff}
`define E_VOLTAGE_REFERENCE_CONTROL {1'b0, 9'h097, 8'h00, 8'hff}
`define E_ASYNC_TRANSMIT_CONTROL {1'b0, 9'h098, 8'h02, 8'hf7}
`define E_BAUD_DIVISOR_LOW {1'b0, 9'h099, 8'h00, 8'hff}
`define E_BAUD_DIVISOR_HIGH {1'b0, 9'h09a, 8'h00, 8'hff}
`define E_PWM_DEADBAND_CONTROL {1'b0, 9'h09b, 8'h00, 8'hff}
`define E_PWM_AUTOSHUTDOWN_CONTROL {1'b0, 9'h09c, 8'h00, 8'hff}
`define E_PWM_STEERING_CONTROL {1'b0, 9'h09d, 8'h01, 8'h1f}
`define E_CONVERTER_RESULT_LOW {1'b1, 9'h09e, 8'h00, 8'hff}
`define E_CONVERTER_CONTROL_1 {1'b0, 9'h09f, 8'h00, 8'hb0}
`define E_WATCHDOG_CONTROL {1'b0, 9'h105, 8'h08, 8'h1f}
`define E_COMPARATOR1_CONTROL {1'b0, 9'h107, 8'h00, 8'hfb}
`define E_COMPARATOR2_CONTROL {1'b0, 9'h108, 8'h00, 8'hfb}
`define E_CORE_IRQ_CONTROL {1'b0, 9'h00b, 8'h00, 8'hff}
`define E_PERIPHERAL_IRQ_FLAGS_1 {1'b0, 9'h00c, 8'h00, 8'hff}
`define E_SERIAL_PORT_CONTROL {1'b0, 9'h014, 8'h00, 8'hff}

// field positions and special values
`define POWER_CONTROL_STATUS_BROWNOUT_BIT 0
`define POWER_CONTROL_STATUS_SBOR_ENABLE_BIT 4
`define POWER_CONTROL_STATUS_ULP_WAKE_BIT 5
`define OSC_STABLE_BIT 3
`define GLOBAL_IRQ_ENABLE_BIT 7
`define CORE_IRQ_DEFAULT_WAKE_BIT 1
`define SERIAL_MODE_HI 3
`define SERIAL_MODE_LO 0
`define SERIAL_MODE_MASK_ACCESS 4'h9
`define WAKE_RELOAD_VALUE 8'hff
`define IRQ_VECTOR_ADDRESS 13'h0004
`define RESET_VECTOR_ADDRESS 13'h0000

`endif

// >>> src/reset_init_values.v
// Contract
// - interrupt wake with global enable set loads program counter with vector 0004h
// - wake from sleep leaves a flag set in core irq control or flags 1; here only an interrupt wake sets a flag, a watchdog wake sets none
// - brown-out reset clears bit 0 of power control status
// - other resets leave bit 0 of power control status unchanged
// - offset 93h reaches address mask only while serial mode field is 1001
// - supply collapse applies power-on values instead of other-reset values
// - unimplemented bit positions read as zero
// - condition bits follow reset cause, unknown bits free, unchanged bits kept
// - global interrupt enable cleared on every reset
//
// Chosen here: strobed register access.
`include "reset_init_values_consts.vh"
`default_nettype none

module reset_init_values
(
  // clock and power-on reset
  input wire clock,
  input wire rst_n,
  // reset and wake causes from pins and supervisors
  input wire supplyLow,
  input wire externalResetPin,
  input wire watchdogReset,
  input wire brownoutReset,
  input wire wakeInterrupt,
  input wire wakeWatchdog,
  input wire oscStable,
  // wake source flags from same-clock interrupt logic
  input wire [2:0] wakeCoreFlags,
  input wire [7:0] wakePeripheralFlags,
  // register port
  input wire [8:0] address,
  input wire [7:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  output reg [7:0] readData,
  // program counter load and status
  output reg programCounterLoad,
  output reg [12:0] programCounterValue,
  output reg globalIrqEnable
);

  localparam NREG = 37;
  localparam [5:0] IDX_POWER_CONTROL_STATUS = 6'd12;
  localparam [5:0] IDX_OSCCTL = 6'd13;
  localparam [5:0] IDX_PERIOD = 6'd16;
  localparam [5:0] IDX_SLAVEADDR = 6'd17;
  localparam [5:0] IDX_ADDRMASK = 6'd18;
  localparam [5:0] IDX_COREIRQ = 6'd34;
  localparam [5:0] IDX_PERFLAGS = 6'd35;
  localparam [5:0] IDX_SERCTL = 6'd36;

  ////////////////////////////////////////////////////////////////////////////////
  // register table lookups

  // one row per register: keep flag, address, power-on image, implemented bits
  function [25:0] entry;
    input [5:0] k;
    begin
      case (k)
        6'd0: entry = `E_CAPTURE2_VALUE_HIGH;
        6'd1: entry = `E_CAPTURE2_CONTROL;
        6'd2: entry = `E_CONVERTER_RESULT_HIGH;
        6'd3: entry = `E_CONVERTER_CONTROL_0;
        6'd4: entry = `E_CORE_OPTION_SETTINGS;
        6'd5: entry = `E_PORT_A_DIRECTION;
        6'd6: entry = `E_PORT_B_DIRECTION;
        6'd7: entry = `E_PORT_C_DIRECTION;
        6'd8: entry = `E_PORT_D_DIRECTION;
        6'd9: entry = `E_PORT_E_DIRECTION;
        6'd10: entry = `E_PERIPHERAL_IRQ_ENABLE_1;
        6'd11: entry = `E_PERIPHERAL_IRQ_ENABLE_2;
        6'd12: entry = `E_POWER_CONTROL_STATUS;
        6'd13: entry = `E_OSCILLATOR_CONTROL;
        6'd14: entry = `E_OSCILLATOR_TUNING;
        6'd15: entry = `E_SERIAL_PORT_CONTROL_2;
        6'd16: entry = `E_TIMER2_PERIOD;
        6'd17: entry = `E_SERIAL_SLAVE_ADDRESS;
        6'd18: entry = `E_SERIAL_ADDRESS_MASK;
        6'd19: entry = `E_SERIAL_PORT_STATE;
        6'd20: entry = `E_PORT_B_PULLUP_ENABLE;
        6'd21: entry = `E_PORT_B_CHANGE_IRQ_ENABLE;
        6'd22: entry = `E_VOLTAGE_REFERENCE_CONTROL;
        6'd23: entry = `E_ASYNC_TRANSMIT_CONTROL;
        6'd24: entry = `E_BAUD_DIVISOR_LOW;
        6'd25: entry = `E_BAUD_DIVISOR_HIGH;
        6'd26: entry = `E_PWM_DEADBAND_CONTROL;
        6'd27: entry = `E_PWM_AUTOSHUTDOWN_CONTROL;
        6'd28: entry = `E_PWM_STEERING_CONTROL;
        6'd29: entry = `E_CONVERTER_RESULT_LOW;
        6'd30: entry = `E_CONVERTER_CONTROL_1;
        6'd31: entry = `E_WATCHDOG_CONTROL;
        6'd32: entry = `E_COMPARATOR1_CONTROL;
        6'd33: entry = `E_COMPARATOR2_CONTROL;
        6'd34: entry = `E_CORE_IRQ_CONTROL;
        6'd35: entry = `E_PERIPHERAL_IRQ_FLAGS_1;
        6'd36: entry = `E_SERIAL_PORT_CONTROL;
        default: entry = 26'h0000000;
      endcase
    end
  endfunction

  function [7:0] porValue;
    input [5:0] k;
    reg [25:0] e;
    begin
      e = entry(k);
      porValue = e[`ENT_POR_HI:`ENT_POR_LO];
    end
  endfunction

  function [7:0] implMask;
    input [5:0] k;
    reg [25:0] e;
    begin
      e = entry(k);
      implMask = e[`ENT_MASK_HI:`ENT_MASK_LO];
    end
  endfunction

  function keepOnOther;
    input [5:0] k;
    reg [25:0] e;
    begin
      e = entry(k);
      keepOnOther = e[`ENT_KEEP];
    end
  endfunction

  // returns {hit, index}; the shared offset is resolved by the serial mode field
  function [6:0] decode;
    input [8:0] a;
    input maskSelect;
    reg [25:0] e;
    reg skip;
    integer k;
    begin
      decode = 7'h00;
      for (k = 0; k < NREG; k = k + 1)
      begin
        e = entry(k[5:0]);
        skip = (k[5:0] == IDX_SLAVEADDR && maskSelect) ||
               (k[5:0] == IDX_ADDRMASK && !maskSelect);
        if (e[`ENT_ADDR_HI:`ENT_ADDR_LO] == a && !skip)
        begin
          decode = {1'b1, k[5:0]};
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg [6:0] syncFirst;
  reg [6:0] syncSecond;
  reg [1:0] wakeLevelPrev;

  // the wake pins sit at bits 5:4; the edge memory has to follow exactly those
  wire [1:0] wakeLevel = syncSecond[5:4];

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncFirst <= 7'h00;
      syncSecond <= 7'h00;
      wakeLevelPrev <= 2'h0;
    end
    else
    begin
      // only the second stage reads the first; logic reads the second stage only
      syncFirst <= {oscStable, wakeWatchdog, wakeInterrupt, brownoutReset,
                    watchdogReset, externalResetPin, supplyLow};
      syncSecond <= syncFirst;
      wakeLevelPrev <= wakeLevel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset and wake decode

  // resets act as levels for as long as they are held; wakes are single events
  wire porRequest = syncSecond[0];
  wire brownout = syncSecond[3];
  wire otherReset = syncSecond[1] | syncSecond[2] | brownout;
  wire anyReset = porRequest | otherReset;
  wire wakeIrqEvent = wakeLevel[0] & ~wakeLevelPrev[0] & ~anyReset;
  wire wakeWdtEvent = wakeLevel[1] & ~wakeLevelPrev[1] & ~anyReset;
  wire wakeEvent = wakeIrqEvent | wakeWdtEvent;
  wire oscStableSync = syncSecond[6];

  ////////////////////////////////////////////////////////////////////////////////
  // register file

  // own registers sit at the end of the table, after the listed ones
  reg [7:0] file [0:NREG-1];
  integer i;

  wire [3:0] serialMode = file[IDX_SERCTL][`SERIAL_MODE_HI:`SERIAL_MODE_LO];
  wire maskSelect = (serialMode == `SERIAL_MODE_MASK_ACCESS);
  wire [6:0] hit = decode(address, maskSelect);
  wire writeHit = writeStrobe & hit[6];
  wire [7:0] coreIrqNow = file[IDX_COREIRQ];
  wire wakeFlagsEmpty = (wakeCoreFlags == 3'h0) && (wakePeripheralFlags == 8'h00);
  // a write is lost in any reset or wake cycle; the file and the mirror agree on that
  wire writeTaken = writeHit & ~anyReset & ~wakeEvent;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // rst_n loads the power-on image; a supply collapse loads the same but takes the oscillator stable bit from oscStableSync
      for (i = 0; i < NREG; i = i + 1)
      begin
        file[i] <= porValue(i[5:0]);
      end
    end
    else
    begin
      for (i = 0; i < NREG; i = i + 1)
      begin
        if (porRequest)
        begin
          file[i] <= porValue(i[5:0]);
        end
        else if (otherReset)
        begin
          // unknown- and unchanged-marked registers keep their contents here
          if (!keepOnOther(i[5:0]))
          begin
            file[i] <= porValue(i[5:0]);
          end
        end
        else if (wakeEvent)
        begin
          if (i[5:0] == IDX_PERIOD || i[5:0] == IDX_ADDRMASK)
          begin
            file[i] <= `WAKE_RELOAD_VALUE;
          end
        end
        else if (writeHit && hit[5:0] == i[5:0])
        begin
          file[i] <= writeData & implMask(i[5:0]);
        end
      end
      // power control status: condition bits follow the reset cause
      if (!porRequest && otherReset)
      begin
        file[IDX_POWER_CONTROL_STATUS][`POWER_CONTROL_STATUS_ULP_WAKE_BIT] <= 1'b0;
        if (brownout)
        begin
          file[IDX_POWER_CONTROL_STATUS][`POWER_CONTROL_STATUS_BROWNOUT_BIT] <= 1'b0;
          file[IDX_POWER_CONTROL_STATUS][`POWER_CONTROL_STATUS_SBOR_ENABLE_BIT] <= 1'b1;
        end
        else
        begin
          // pin and watchdog resets must not disturb the brown-out record
          file[IDX_POWER_CONTROL_STATUS][`POWER_CONTROL_STATUS_BROWNOUT_BIT] <= file[IDX_POWER_CONTROL_STATUS][`POWER_CONTROL_STATUS_BROWNOUT_BIT];
        end
      end
      // oscillator stable flag is a live condition bit, never stored from software
      file[IDX_OSCCTL][`OSC_STABLE_BIT] <= oscStableSync;
      // wake flags win over any software write in the same cycle
      if (wakeIrqEvent)
      begin
        file[IDX_PERFLAGS] <= file[IDX_PERFLAGS] | wakePeripheralFlags;
        if (wakeFlagsEmpty)
        begin
          file[IDX_COREIRQ][`CORE_IRQ_DEFAULT_WAKE_BIT] <= 1'b1;
        end
        else
        begin
          file[IDX_COREIRQ] <= coreIrqNow | {5'h00, wakeCoreFlags};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // program counter load and global enable mirror

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      programCounterLoad <= 1'b1;
      programCounterValue <= `RESET_VECTOR_ADDRESS;
      globalIrqEnable <= 1'b0;
    end
    else
    begin
      programCounterLoad <= 1'b0;
      // the reset vector stays presented for as long as a reset level stands
      if (anyReset)
      begin
        programCounterLoad <= 1'b1;
        programCounterValue <= `RESET_VECTOR_ADDRESS;
        globalIrqEnable <= 1'b0;
      end
      else
      begin
        // the enable comes from bit 7 of the stored register, a bit that a wake never alters
        if (wakeIrqEvent && coreIrqNow[`GLOBAL_IRQ_ENABLE_BIT])
        begin
          programCounterLoad <= 1'b1;
          programCounterValue <= `IRQ_VECTOR_ADDRESS;
        end
        if (writeTaken && hit[5:0] == IDX_COREIRQ)
        begin
          globalIrqEnable <= writeData[`GLOBAL_IRQ_ENABLE_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port: data valid only in the cycle after the strobe

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readData <= 8'h00;
    end
    else if (readStrobe && hit[6])
    begin
      readData <= file[hit[5:0]] & implMask(hit[5:0]);
    end
    else if (readStrobe && !hit[6])
    begin
      // unmapped offsets answer zero, never the last value read
      readData <= 8'h00;
    end
    else
    begin
      readData <= 8'h00;
    end
  end

endmodule // reset_init_values

`default_nettype wire

// >>> bench/reset_init_values_assertions.sv
`default_nettype none
module reset_init_values_checker (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // reset and wake causes
  input wire supplyLow,
  input wire externalResetPin,
  input wire watchdogReset,
  input wire brownoutReset,
  input wire wakeInterrupt,
  // register port
  input wire [8:0] address,
  input wire readStrobe,
  input wire [7:0] readData,
  // program counter and status
  input wire programCounterLoad,
  input wire [12:0] programCounterValue,
  input wire globalIrqEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire anyRst = supplyLow | externalResetPin | watchdogReset | brownoutReset;
  ////////////////////////////////////////
  a_read_idle_zero: assert property (!readStrobe |=> readData == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (readStrobe && address == 9'h1ff |=> readData == 8'h00)
    else $error("unmapped read not zero");
  a_unimpl_bits: assert property (readStrobe && address == 9'h089 |=> readData[7:4] == 4'h0)
    else $error("unimplemented bits not zero");
  // five samples cover the two sync stages and the register
  a_reset_hold: assert property (anyRst[*5] |-> programCounterLoad && !globalIrqEnable
    && programCounterValue == 13'h0000) else $error("reset did not clear enable and pc");
  a_wake_vector: assert property ($rose(wakeInterrupt) && globalIrqEnable && !anyRst
    |-> ##[1:5] programCounterLoad && programCounterValue == 13'h0004)
    else $error("interrupt wake did not load vector");
  a_vector_needs_gie: assert property (programCounterLoad && programCounterValue == 13'h0004
    |-> $past(globalIrqEnable)) else $error("vector load without enable");
  a_no_vector_off: assert property ($rose(wakeInterrupt) && !globalIrqEnable && !anyRst
    |-> (!programCounterLoad)[*6]) else $error("pc loaded with enable clear");
  a_load_pulse: assert property (programCounterLoad && programCounterValue == 13'h0004
    |=> !programCounterLoad) else $error("vector load longer than one cycle");
  a_gie_mirror: assert property (readStrobe && address == 9'h00b
    |=> readData[7] == globalIrqEnable) else $error("enable mirror differs");
  c_wake_load: cover property (programCounterLoad && programCounterValue == 13'h0004);
  c_unmapped: cover property (readStrobe && address == 9'h1ff);
  c_reset_hold: cover property (anyRst[*5]);
endmodule // reset_init_values_checker

bind reset_init_values reset_init_values_checker u_chk (.clock, .rst_n, .supplyLow,
  .externalResetPin, .watchdogReset, .brownoutReset, .wakeInterrupt, .address,
  .readStrobe, .readData, .programCounterLoad, .programCounterValue, .globalIrqEnable);
`default_nettype wire

// >>> bench/reset_init_values_test.sv
`default_nettype none
module reset_init_values_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] cause = 4'h0; // {supply, brown-out, watchdog, pin}
  logic wakeInterrupt = 1'b0;
  logic wakeWatchdog = 1'b0;
  logic [7:0] wakePeripheralFlags = 8'h00;
  logic oscStable = 1'b1;
  logic [2:0] wakeCoreFlags = 3'h0;
  logic [8:0] address = 9'h000;
  logic [7:0] writeData = 8'h00;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  wire [7:0] readData;
  wire programCounterLoad;
  wire [12:0] programCounterValue;
  wire globalIrqEnable;
  int errTotal = 0;
  int totalChecks = 0;
  logic [31:0] seed = 32'h08fc;
  logic [15:0] seen;
  logic [7:0] old;
  // {address, value}; oscillator reads bit 3 from the stable input, high until the wake test ends
  logic [16:0] tbl [12] = '{{9'h081, 8'hff}, {9'h085, 8'hff}, {9'h089, 8'h0f},
    {9'h08e, 8'h10}, {9'h08f, 8'h68}, {9'h092, 8'hff}, {9'h093, 8'h00}, {9'h098, 8'h02},
    {9'h09d, 8'h01}, {9'h09f, 8'h00}, {9'h105, 8'h08}, {9'h1ff, 8'h00}};
  // {address, implemented mask}
  logic [16:0] msk [6] = '{{9'h089, 8'h0f}, {9'h090, 8'h1f}, {9'h09d, 8'h1f},
    {9'h105, 8'h1f}, {9'h01d, 8'h3f}, {9'h09f, 8'hb0}};

  reset_init_values dut (.clock, .rst_n, .supplyLow(cause[3]), .externalResetPin(cause[0]),
    .watchdogReset(cause[1]), .brownoutReset(cause[2]), .wakeInterrupt, .wakeWatchdog,
    .oscStable, .wakeCoreFlags, .wakePeripheralFlags, .address, .writeData,
    .writeStrobe, .readStrobe, .readData, .programCounterLoad, .programCounterValue,
    .globalIrqEnable);

  initial forever #5 clock = ~clock;
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // supply loss gives power-on value; brown-out also drops bit 0 and sets bit 4
  function automatic logic [7:0] expPcon(input int k, input logic [7:0] v);
    if (k == 3)
      return 8'h10;
    return k == 2 ? (v & 8'h1e) | 8'h10 : v & 8'h1f;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1;
    chk({8'h00, readData}, {8'h00, e});
  endtask
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    foreach (tbl[i]) rd(tbl[i][16:8], tbl[i][7:0]);
    $display("test power_on done");
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      wr(msk[i % 6][16:8], seed[7:0]);
      rd(msk[i % 6][16:8], seed[7:0] & msk[i % 6][7:0]);
    end
    $display("test readback done");
    wr(9'h014, 8'h08);
    wr(9'h093, 8'h3c);
    wr(9'h014, 8'h09);
    wr(9'h093, 8'hc5);
    rd(9'h093, 8'hc5);
    wr(9'h014, 8'h08);
    rd(9'h093, 8'h3c);
    $display("test shared_place done");
    for (int w = 0; w < 3; w++)
    begin
      wr(9'h014, 8'h08);
      wr(9'h093, 8'h11);
      wr(9'h014, 8'h09);
      wr(9'h092, 8'h5a);
      wr(9'h093, 8'h5a);
      wr(9'h00c, 8'h00);
      wr(9'h00b, w == 1 ? 8'h00 : 8'h80);
      wakePeripheralFlags <= w == 1 ? 8'h40 : 8'h00;
      wakeCoreFlags <= w == 1 ? 3'h4 : 3'h0;
      {wakeWatchdog, wakeInterrupt} <= w == 2 ? 2'b10 : 2'b01;
      seen = 16'h0000;
      repeat (8)
      begin
        @(posedge clock);
        #1;
        if (programCounterLoad === 1'b1)
          seen = {3'h1, programCounterValue};
      end
      chk(seen, w == 0 ? 16'h2004 : 16'h0000);
      @(posedge clock);
      {wakeWatchdog, wakeInterrupt} <= 2'b00;
      rd(9'h092, 8'hff);
      rd(9'h093, 8'hff);
      rd(9'h00b, w == 0 ? 8'h82 : w == 1 ? 8'h04 : 8'h80);
      rd(9'h00c, w == 1 ? 8'h40 : 8'h00);
      wr(9'h014, 8'h08);
      rd(9'h093, 8'h11);
    end
    @(posedge clock);
    oscStable <= 1'b0;
    repeat (3) @(posedge clock);
    rd(9'h08f, 8'h60);
    $display("test wake done");
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      old = seed[7:0] & 8'h33;
      wr(9'h08e, old);
      wr(9'h01c, 8'hab);
      wr(9'h095, 8'h5a);
      wr(9'h090, 8'h15);
      wr(9'h00b, 8'h80);
      cause <= 4'h1 << k;
      repeat (6) @(posedge clock);
      cause <= 4'h0;
      repeat (4) @(posedge clock);
      rd(9'h08e, expPcon(k, old));
      rd(9'h01c, k == 3 ? 8'h00 : 8'hab);
      rd(9'h095, 8'hff);
      rd(9'h00b, 8'h00);
      rd(9'h090, k == 3 ? 8'h00 : 8'h15);
      chk({15'h0000, globalIrqEnable}, 16'h0000);
    end
    $display("test resets done");
    printVerdict();
  end
  // the whole sequence needs about 400 cycles
  initial
  begin
    #200000;
    errTotal++;
    printVerdict();
  end
endmodule // reset_init_values_test
`default_nettype wire
